// ==== rtl/nvsram_ctl.sv ====
// host-side controller driving the nonvolatile sram pins
// Notes on behaviour
// - store needs reads 0000,1555,0AAA,1FFF,10F0,0F0F in that order.
// - recall uses same five reads then 0F0E as the sixth.
// - write strobe held high through all six sequence reads.
// - host never issues the factory test sequence ending 139C.
// - host holds store/busy low at least 250 ns to trigger a store.
// - each sequence step is one chip-select low pulse.
// - other accesses between steps abort; host issues six reads back to back.
`timescale 1ns/1ps
`default_nettype none
`include "nvsram_ctl_params.svh"
module nvsram_ctl
    import nvsram_ctl_pkg::*;
#(
    parameter int unsigned STORE_CYC   = `CYC_STORE,
    parameter int unsigned RESTORE_CYC = `CYC_RESTORE,
    parameter int unsigned RECALL_CYC  = `CYC_RECALL
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // user command port
    input  wire logic        req_valid_i,
    input  wire cmd_e        req_cmd_i,
    input  wire logic [12:0] req_addr_i,
    input  wire logic [7:0]  req_wdata_i,
    output var  logic        req_ready_o,
    output var  logic        rsp_done_o,
    output var  logic [7:0]  rsp_rdata_o,
    // memory pins
    output var  logic        cs_n_o,
    output var  logic        we_n_o,
    output var  logic        oe_n_o,
    output var  logic [12:0] addr_in_o,
    input  wire logic [7:0]  data_io_i,
    output var  logic [7:0]  data_io_o,
    output var  logic        data_io_oe_o,
    input  wire logic        hw_store_busy_n_i,
    output var  logic        hw_store_busy_n_o,
    output var  logic        hw_store_busy_n_oe_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [12:0] seq_addr(input logic [2:0] s, input cmd_e c);
        case (s)
            3'd0:    seq_addr = `SEQ_ADDR0;
            3'd1:    seq_addr = `SEQ_ADDR1;
            3'd2:    seq_addr = `SEQ_ADDR2;
            3'd3:    seq_addr = `SEQ_ADDR3;
            3'd4:    seq_addr = `SEQ_ADDR4;
            default: seq_addr = (c == CMD_RECALL) ? `SEQ_RECALL : `SEQ_STORE;
        endcase
    endfunction : seq_addr

    function automatic logic [23:0] cyc(input int unsigned n);
        cyc = 24'(n);
    endfunction : cyc

    ctl_s st_reg;
    ctl_s st_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.cnt = (st_reg.cnt != 24'h0000_00) ? st_reg.cnt - 24'h0000_01 : st_reg.cnt;
        case (st_reg.state)
            ST_POWERUP: begin
                if (st_reg.cnt == 24'h0000_00) begin
                    st_next.state = ST_IDLE;
                    st_next.ready = 1'b1;
                end
            end
            ST_IDLE: begin
                if (req_valid_i && hw_store_busy_n_i) begin
                    st_next.ready = 1'b0;
                    st_next.cmd = req_cmd_i;
                    st_next.wdata = req_wdata_i;
                    st_next.addr = req_addr_i;
                    st_next.step = 3'd0;
                    if (req_cmd_i == CMD_HSTORE) begin
                        st_next.state = ST_PIN_LOW;
                        st_next.pins.busy_out = 1'b0;
                        st_next.pins.busy_oe = 1'b1;
                        st_next.cnt = cyc(`CYC_PIN_PW);
                    end else begin
                        st_next.state = ST_ACCESS;
                        st_next.pins.cs_n = 1'b0;
                        st_next.cnt = cyc(`CYC_ACC);
                        if (req_cmd_i == CMD_WRITE) begin
                            st_next.pins.addr = req_addr_i;
                            st_next.pins.we_n = 1'b0;
                            st_next.pins.dout = req_wdata_i;
                            st_next.pins.dout_en = 1'b1;
                        end else if (req_cmd_i == CMD_READ) begin
                            st_next.pins.addr = req_addr_i;
                            st_next.pins.oe_n = 1'b0;
                        end else begin
                            st_next.pins.addr = seq_addr(3'd0, req_cmd_i);
                            st_next.pins.oe_n = 1'b1;
                        end
                    end
                end
            end
            ST_ACCESS: begin
                if (st_reg.cnt == 24'h0000_00) begin
                    st_next.pins.cs_n = 1'b1;
                    st_next.pins.we_n = 1'b1;
                    st_next.pins.oe_n = 1'b1;
                    st_next.pins.dout_en = 1'b0;
                    st_next.rdata = data_io_i;
                    st_next.state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (st_reg.cmd == CMD_STORE || st_reg.cmd == CMD_RECALL) begin
                    if (st_reg.step == 3'd5) begin
                        st_next.state = ST_NV_WAIT;
                        st_next.cnt = (st_reg.cmd == CMD_STORE) ? cyc(STORE_CYC) : cyc(RECALL_CYC);
                    end else begin
                        // next distinct address, back to back, reads only
                        st_next.step = st_reg.step + 3'd1;
                        st_next.pins.addr = seq_addr(st_reg.step + 3'd1, st_reg.cmd);
                        st_next.pins.cs_n = 1'b0;
                        st_next.cnt = cyc(`CYC_ACC);
                        st_next.state = ST_ACCESS;
                    end
                end else begin
                    st_next.done = 1'b1;
                    st_next.ready = 1'b1;
                    st_next.state = ST_IDLE;
                end
            end
            ST_PIN_LOW: begin
                if (st_reg.cnt == 24'h0000_00) begin
                    st_next.pins.busy_out = 1'b1;
                    st_next.pins.busy_oe = 1'b0;
                    st_next.state = ST_PIN_REL;
                    st_next.cnt = cyc(STORE_CYC);
                end
            end
            ST_PIN_REL: begin
                // wait for the line to read high again, or for the STORE_CYC count to run out
                if (hw_store_busy_n_i || st_reg.cnt == 24'h0000_00) begin
                    st_next.state = ST_RECOVER;
                    st_next.cnt = cyc(`CYC_INH_OFF);
                end
            end
            ST_NV_WAIT: begin
                if (st_reg.cnt == 24'h0000_00) begin
                    st_next.state = ST_RECOVER;
                    st_next.cnt = cyc(`CYC_INH_OFF);
                end
            end
            ST_RECOVER: begin
                if (st_reg.cnt == 24'h0000_00 && hw_store_busy_n_i) begin
                    st_next.state = ST_IDLE;
                    st_next.ready = 1'b1;
                    st_next.done = 1'b1;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
                st_next.ready = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.state <= ST_POWERUP;
            st_reg.cmd <= CMD_READ;
            st_reg.pins.cs_n <= 1'b1;
            st_reg.pins.we_n <= 1'b1;
            st_reg.pins.oe_n <= 1'b1;
            st_reg.pins.busy_out <= 1'b1;
            st_reg.cnt <= cyc(RESTORE_CYC);
        end else begin
            st_reg <= st_next;
        end
    end

    assign req_ready_o          = st_reg.ready;
    assign rsp_done_o           = st_reg.done;
    assign rsp_rdata_o          = st_reg.rdata;
    assign cs_n_o               = st_reg.pins.cs_n;
    assign we_n_o               = st_reg.pins.we_n;
    assign oe_n_o               = st_reg.pins.oe_n;
    assign addr_in_o            = st_reg.pins.addr;
    assign data_io_o            = st_reg.pins.dout;
    assign data_io_oe_o         = st_reg.pins.dout_en;
    assign hw_store_busy_n_o    = st_reg.pins.busy_out;
    assign hw_store_busy_n_oe_o = st_reg.pins.busy_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_seq_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.cmd inside {CMD_STORE, CMD_RECALL} && !st_reg.pins.cs_n) |-> st_reg.pins.we_n)
        else $error("write strobe low during sequence");
    a_seq_order: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.cmd inside {CMD_STORE, CMD_RECALL} && !st_reg.pins.cs_n)
        |-> st_reg.pins.addr == seq_addr(st_reg.step, st_reg.cmd))
        else $error("sequence address out of order");
    a_no_test_seq: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_reg.pins.cs_n && st_reg.step == 3'd5 |-> st_reg.pins.addr != `SEQ_TEST)
        else $error("test sequence issued");
    a_last_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.cmd == CMD_RECALL && st_reg.step == 3'd5 && !st_reg.pins.cs_n)
        |-> st_reg.pins.addr == `SEQ_RECALL)
        else $error("recall sixth address wrong");
    a_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(st_reg.pins.busy_oe & ~st_reg.pins.busy_out) |-> $past(st_reg.pins.busy_oe, 13))
        else $error("store pulse too short");
    a_quiet_nv: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.state inside {ST_NV_WAIT, ST_PIN_REL, ST_POWERUP} |-> st_reg.pins.cs_n)
        else $error("access during nonvolatile cycle");
    a_step_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(st_reg.pins.addr) |-> st_reg.pins.cs_n || $past(st_reg.pins.cs_n))
        else $error("address changed with chip select low");
    a_busy_drain: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.pins.busy_oe |-> !st_reg.pins.busy_out)
        else $error("store pin driven high");
    a_bus_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.pins.dout_en |-> !st_reg.pins.we_n && !st_reg.pins.cs_n)
        else $error("data driven outside a write");
endmodule : nvsram_ctl
`default_nettype wire

// ==== rtl/nvsram_ctl_params.svh ====
// constants for the nonvolatile sram host controller
`ifndef NVSRAM_CTL_PARAMS_SVH
`define NVSRAM_CTL_PARAMS_SVH
`define SEQ_ADDR0      13'h0000
`define SEQ_ADDR1      13'h1555
`define SEQ_ADDR2      13'h0AAA
`define SEQ_ADDR3      13'h1FFF
`define SEQ_ADDR4      13'h10F0
`define SEQ_STORE      13'h0F0F
`define SEQ_RECALL     13'h0F0E
`define SEQ_TEST       13'h139C
`define CLK_NS         20
`define T_ACC_NS       45
`define T_PIN_PW_NS    250
`define T_SW_DIS_NS    600
`define T_INH_OFF_NS   700
`define T_STORE_NS     10000000
`define T_RECALL_NS    20000
`define T_RESTORE_NS   650000
`define CYC_ACC        ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_PIN_PW     ((`T_PIN_PW_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_INH_OFF    ((`T_INH_OFF_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_STORE      ((`T_STORE_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_RECALL     ((`T_RECALL_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_RESTORE    ((`T_RESTORE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== rtl/nvsram_ctl_pkg.sv ====
// types for the nonvolatile sram host controller
`default_nettype none
package nvsram_ctl_pkg;
    typedef enum logic [7:0] {
        ST_POWERUP = 8'b0000_0001,
        ST_IDLE    = 8'b0000_0010,
        ST_ACCESS  = 8'b0000_0100,
        ST_GAP     = 8'b0000_1000,
        ST_PIN_LOW = 8'b0001_0000,
        ST_PIN_REL = 8'b0010_0000,
        ST_NV_WAIT = 8'b0100_0000,
        ST_RECOVER = 8'b1000_0000
    } ctl_state_e;

    typedef enum logic [2:0] {
        CMD_READ   = 3'b001,
        CMD_WRITE  = 3'b010,
        CMD_STORE  = 3'b011,
        CMD_RECALL = 3'b100,
        CMD_HSTORE = 3'b101
    } cmd_e;

    typedef struct packed {
        logic        cs_n;
        logic        we_n;
        logic        oe_n;
        logic [12:0] addr;
        logic [7:0]  dout;
        logic        dout_en;
        logic        busy_out;
        logic        busy_oe;
    } pins_s;

    typedef struct packed {
        ctl_state_e  state;
        pins_s       pins;
        cmd_e        cmd;
        logic [7:0]  wdata;
        logic [12:0] addr;
        logic [2:0]  step;
        logic [23:0] cnt;
        logic        ready;
        logic        done;
        logic [7:0]  rdata;
    } ctl_s;
endpackage : nvsram_ctl_pkg
`default_nettype wire

// ==== sim/nvsram_dev_model.sv ====
// behavioural model of the nonvolatile sram behind the controller
`timescale 1ns/1ps
`default_nettype none
`include "nvsram_ctl_params.svh"
module nvsram_dev_model #(
    parameter int NV_CYC  = 30,
    parameter int PWR_CYC = 15
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // memory pins
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [12:0] addr_in_i,
    input  wire logic [7:0]  data_i,
    output var  logic [7:0]  data_o,
    input  wire logic        busy_line_i,
    output var  logic        busy_pull_o,
    // event counts
    output var  int          store_cnt_o,
    output var  int          recall_cnt_o
);
    logic [7:0]  mem [8192];
    logic [7:0]  nv  [8192];
    logic [12:0] seq [5] = '{`SEQ_ADDR0, `SEQ_ADDR1, `SEQ_ADDR2, `SEQ_ADDR3, `SEQ_ADDR4};
    logic [7:0]  last = 8'h00;
    logic        cs_q, dirty, hw, rd;
    int          step, busy;
    // -------------------------------------------------------------
    // pins and sequence detector
    // -------------------------------------------------------------
    assign rd = !cs_n_i && !oe_n_i && we_n_i && busy_line_i && busy == 0;
    assign data_o = rd ? mem[addr_in_i] : ~last;
    assign busy_pull_o = hw && busy > 0;
    always_ff @(posedge clk_i) begin
        last <= data_o;
        cs_q <= cs_n_i;
        if (rst_i) begin
            step <= 0;
            busy <= PWR_CYC;
            hw <= 1'b0;
            dirty <= 1'b0;
            store_cnt_o <= 0;
            recall_cnt_o <= 0;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end else if (!busy_line_i) begin
            if (dirty && !hw) begin
                hw <= 1'b1;
                busy <= NV_CYC;
                dirty <= 1'b0;
                nv <= mem;
                store_cnt_o <= store_cnt_o + 1;
            end
        end else begin
            hw <= 1'b0;
            if (!cs_n_i && !we_n_i) begin
                mem[addr_in_i] <= data_i;
                dirty <= 1'b1;
                step <= 0;
            end else if (!cs_n_i && cs_q) begin
                if (step == 5 && addr_in_i == `SEQ_STORE) begin
                    busy <= NV_CYC;
                    nv <= mem;
                    dirty <= 1'b0;
                    store_cnt_o <= store_cnt_o + 1;
                    step <= 0;
                end else if (step == 5 && addr_in_i == `SEQ_RECALL) begin
                    busy <= NV_CYC / 2;
                    mem <= nv;
                    recall_cnt_o <= recall_cnt_o + 1;
                    step <= 0;
                end else if (step < 5 && addr_in_i == seq[step]) begin
                    step <= step + 1;
                end else begin
                    step <= int'(addr_in_i == `SEQ_ADDR0);
                end
            end
        end
    end
endmodule : nvsram_dev_model
`default_nettype wire

// ==== sim/nvsram_store_recall_control_tb_top.sv ====
// testbench for the nonvolatile sram host controller
`timescale 1ns/1ps
`default_nettype none
module nvsram_store_recall_control_tb_top;
    import nvsram_ctl_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req_valid_i = 1'b0;
    cmd_e        req_cmd_i = CMD_READ;
    logic [12:0] req_addr_i = 13'h0000;
    logic [7:0]  req_wdata_i = 8'h00;
    logic        req_ready_o, rsp_done_o, cs_n_o, we_n_o, oe_n_o, data_io_oe_o;
    logic        busy_o, busy_oe, dev_pull, busy_line;
    logic [7:0]  rsp_rdata_o, data_io_o, dev_q;
    logic [12:0] addr_in_o;
    int          err_count = 0;
    int          tests_run = 0;
    int          st_cnt, rc_cnt, s0;
    assign busy_line = !((busy_oe && !busy_o) || dev_pull);
    always #10 clk_i = ~clk_i;
    nvsram_ctl #(.STORE_CYC(50), .RESTORE_CYC(20), .RECALL_CYC(20)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .rsp_done_o(rsp_done_o), .rsp_rdata_o(rsp_rdata_o), .cs_n_o(cs_n_o), .we_n_o(we_n_o),
        .oe_n_o(oe_n_o), .addr_in_o(addr_in_o), .data_io_i(dev_q), .data_io_o(data_io_o),
        .data_io_oe_o(data_io_oe_o), .hw_store_busy_n_i(busy_line), .hw_store_busy_n_o(busy_o),
        .hw_store_busy_n_oe_o(busy_oe));
    nvsram_dev_model model (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o),
        .addr_in_i(addr_in_o), .data_i(data_io_oe_o ? data_io_o : ~data_io_o), .data_o(dev_q),
        .busy_line_i(busy_line), .busy_pull_o(dev_pull), .store_cnt_o(st_cnt), .recall_cnt_o(rc_cnt));
    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic issue(input cmd_e c, input logic [12:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while ((req_ready_o !== 1'b1 || busy_line !== 1'b1) && n < 2000) begin
            @(posedge clk_i);
            #1 n++;
        end
        req_valid_i = 1'b1;
        req_cmd_i = c;
        req_addr_i = a;
        req_wdata_i = d;
        @(posedge clk_i);
        #1 req_valid_i = 1'b0;
        n = 0;
        while (rsp_done_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("done", 1, rsp_done_o);
    endtask : issue
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_powerup();
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("power-up wait", 1, n >= 20 && n < 100);
    endtask : t_powerup
    task automatic t_rw();
        issue(CMD_WRITE, 13'h1ABC, 8'h5A);
        issue(CMD_WRITE, 13'h0000, 8'hC3);
        issue(CMD_READ, 13'h1ABC, 8'h00);
        check("read data", 8'h5A, rsp_rdata_o);
        issue(CMD_READ, 13'h0000, 8'h00);
        check("read data", 8'hC3, rsp_rdata_o);
    endtask : t_rw
    task automatic t_abort();
        s0 = st_cnt;
        issue(CMD_READ, 13'h0000, 8'h00);
        issue(CMD_READ, 13'h1555, 8'h00);
        issue(CMD_READ, 13'h1555, 8'h00);
        issue(CMD_READ, 13'h0AAA, 8'h00);
        issue(CMD_READ, 13'h1FFF, 8'h00);
        issue(CMD_READ, 13'h10F0, 8'h00);
        issue(CMD_READ, 13'h0F0F, 8'h00);
        check("aborted store", s0, st_cnt);
    endtask : t_abort
    task automatic t_sw();
        s0 = st_cnt;
        issue(CMD_WRITE, 13'h0123, 8'hA5);
        issue(CMD_STORE, 13'h0000, 8'h00);
        check("store count", s0 + 1, st_cnt);
        issue(CMD_WRITE, 13'h0123, 8'h3C);
        issue(CMD_RECALL, 13'h0000, 8'h00);
        check("recall count", 1, rc_cnt);
        check("store count", s0 + 1, st_cnt);
        issue(CMD_READ, 13'h0123, 8'h00);
        check("recalled data", 8'hA5, rsp_rdata_o);
    endtask : t_sw
    task automatic t_hw();
        s0 = st_cnt;
        issue(CMD_WRITE, 13'h0042, 8'h77);
        issue(CMD_HSTORE, 13'h0000, 8'h00);
        check("pin store count", s0 + 1, st_cnt);
        check("line released", 1, busy_line);
        issue(CMD_HSTORE, 13'h0000, 8'h00);
        check("clean pin store", s0 + 1, st_cnt);
        issue(CMD_READ, 13'h0042, 8'h00);
        check("data after store", 8'h77, rsp_rdata_o);
    endtask : t_hw
    initial begin
        repeat (12) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_powerup();
        t_rw();
        t_abort();
        t_sw();
        t_hw();
        complete_run();
    end
    initial begin
        #400000;
        err_count++;
        complete_run();
    end
endmodule : nvsram_store_recall_control_tb_top
`default_nettype wire
